/* dur_pkg.sv */
`default_nettype none

// ****************************************************************
// Shared constants for the update and reset control
// ****************************************************************
package dur_pkg;
    localparam int N_CH = 4;
    localparam int DATA_W = 16;
    localparam int FRAME_W = 24;
    localparam int BYTES_PER_FRAME = 3;
    localparam int CNT_W = 2;

    // Frame field positions
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 20;
    localparam int ADDR_MSB = 19;
    localparam int ADDR_LSB = 16;
    localparam int DATA_MSB = 15;
    localparam int DATA_LSB = 0;
    localparam int MASK_MSB = 3;
    localparam int MASK_LSB = 0;
    localparam int REF_BIT = 0;

    // Command codes
    localparam logic [3:0] CMD_WRITE_IN = 4'h1;
    localparam logic [3:0] CMD_UPDATE = 4'h2;
    localparam logic [3:0] CMD_WRITE_UPD = 4'h3;
    localparam logic [3:0] CMD_STROBE_MASK = 4'h5;
    localparam logic [3:0] CMD_SOFT_RESET = 4'h6;
    localparam logic [3:0] CMD_REF_SETUP = 4'h7;

    // Reset values
    localparam logic [DATA_W-1:0] ZERO_CODE = 16'h0000;
    localparam logic [DATA_W-1:0] MID_CODE = 16'h8000;
    localparam logic [N_CH-1:0] MASK_RESET = 4'h0;
    localparam logic REF_RESET = 1'b0;

    typedef enum logic [1:0] {
        ST_INIT = 2'b01,
        ST_RUN = 2'b10
    } dur_state_e;
endpackage

`default_nettype wire

/* dur_frame_rx.sv */
`default_nettype none

// ****************************************************************
// Byte-to-frame assembler: command byte, data MSB, data LSB
// ****************************************************************
module dur_frame_rx
    import dur_pkg::*;
(
    input wire logic ref_clk_i,               // System clock
    input wire logic rst_i,                   // Power-on reset
    input wire logic start_i,                 // Start with own address acked
    input wire logic byte_valid_i,            // Acked data byte strobe
    input wire logic [7:0] byte_i,            // Acked data byte
    input wire logic stop_i,                  // Stop condition
    output logic frame_valid_o,               // Whole frame pulse
    output logic [dur_pkg::FRAME_W-1:0] frame_o // Assembled frame
);
    logic [CNT_W-1:0] count;
    logic [FRAME_W-1:0] shift;
    logic armed;
    wire last_byte = byte_valid_i && armed && (count == CNT_W'(BYTES_PER_FRAME - 1));
    wire [FRAME_W-1:0] next_shift = {shift[FRAME_W-9:0], byte_i};

    // Short frames are dropped: nothing leaves before the third byte
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || start_i || stop_i)
        begin
            count <= '0;
            armed <= start_i && !rst_i;
            frame_valid_o <= 1'b0;
        end
        else if (byte_valid_i && armed)
        begin
            count <= last_byte ? '0 : count + 1'b1;
            armed <= !last_byte;
            frame_valid_o <= last_byte;
        end
        else
        begin
            frame_valid_o <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            shift <= '0;
            frame_o <= '0;
        end
        else
        begin
            if (byte_valid_i && armed)
            begin
                shift <= next_shift;
            end
            if (last_byte)
            begin
                frame_o <= next_shift;
            end
        end
    end
endmodule

`default_nettype wire

/* dur_ctrl.sv */
`default_nettype none

module dur_ctrl
    import dur_pkg::*;
(
    input wire logic ref_clk_i,                  // System clock, 25 MHz
    input wire logic rst_i,                      // Power-on reset, active high
    input wire logic start_i,                    // Start, own address acked
    input wire logic byte_valid_i,               // Acked data byte strobe
    input wire logic [7:0] byte_i,               // Acked data byte
    input wire logic stop_i,                     // Stop condition
    input wire logic load_strobe_n_i,            // Load strobe pin, active low
    input wire logic reset_n_i,                  // Hardware reset pin, active low
    input wire logic reset_level_select_i,       // 0 zero scale, 1 midscale
    output logic [dur_pkg::N_CH-1:0][dur_pkg::DATA_W-1:0] dac_code_o, // DAC registers
    output logic [dur_pkg::N_CH-1:0][dur_pkg::DATA_W-1:0] input_reg_o, // Input registers
    output logic [dur_pkg::N_CH-1:0] load_strobe_mask_o, // Strobe mask
    output logic reference_off_o,                // Reference disabled
    output logic init_done_o                     // Initialisation complete
);
    import dur_pkg::*;

    // ****************************************************************
    // Frame reception
    // ****************************************************************
    logic frame_valid;
    logic [FRAME_W-1:0] frame;

    dur_frame_rx u_rx (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .start_i(start_i),
        .byte_valid_i(byte_valid_i),
        .byte_i(byte_i),
        .stop_i(stop_i),
        .frame_valid_o(frame_valid),
        .frame_o(frame)
    );

    // ****************************************************************
    // Decode
    // ****************************************************************
    function automatic logic is_cmd(input logic [FRAME_W-1:0] f, input logic [3:0] code);
        is_cmd = (f[CMD_MSB:CMD_LSB] == code);
    endfunction

    dur_state_e state;
    dur_state_e next_state;
    logic strobe_q;

    wire [3:0] cmd = frame[CMD_MSB:CMD_LSB];
    wire [N_CH-1:0] addr = frame[ADDR_MSB:ADDR_LSB];
    wire [DATA_W-1:0] data = frame[DATA_MSB:DATA_LSB];
    wire initialised = (state == ST_RUN);
    wire cmd_ok = frame_valid && initialised;
    wire do_write_in = cmd_ok && is_cmd(frame, CMD_WRITE_IN);
    wire do_update = cmd_ok && is_cmd(frame, CMD_UPDATE);
    wire do_write_upd = cmd_ok && is_cmd(frame, CMD_WRITE_UPD);
    wire do_mask = cmd_ok && is_cmd(frame, CMD_STROBE_MASK);
    wire do_soft_reset = cmd_ok && is_cmd(frame, CMD_SOFT_RESET);
    wire do_ref = cmd_ok && is_cmd(frame, CMD_REF_SETUP);
    // Edge seen only after init, so power-on strobe activity is lost
    wire strobe_fall = strobe_q && !load_strobe_n_i && initialised;
    wire [DATA_W-1:0] clear_code = reset_level_select_i ? MID_CODE : ZERO_CODE;
    // Clear dominates every update source in the same cycle
    wire clear = !initialised || !reset_n_i || do_soft_reset;

    // ****************************************************************
    // Initialisation sequence
    // ****************************************************************
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_INIT:
            begin
                if (reset_n_i)
                begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN:
            begin
                next_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            state <= ST_INIT;
            strobe_q <= 1'b1;
        end
        else
        begin
            state <= next_state;
            strobe_q <= load_strobe_n_i;
        end
    end

    assign init_done_o = state[1];

    // ****************************************************************
    // Per-channel register update
    // ****************************************************************
    logic [N_CH-1:0][DATA_W-1:0] next_dac;
    logic [N_CH-1:0][DATA_W-1:0] next_input;

    genvar ch;
    generate
        for (ch = 0; ch < N_CH; ch++)
        begin : g_ch
            wire sel = addr[ch];
            wire wr_in = sel && (do_write_in || do_write_upd);
            // Pin low on a write-input passes data straight through, mask or not
            wire data_to_dac = sel && (do_write_upd
                || (do_write_in && !load_strobe_n_i));
            wire copy_to_dac = (sel && do_update)
                || (strobe_fall && !load_strobe_mask_o[ch]);
            assign next_input[ch] = clear ? clear_code
                : wr_in ? data : input_reg_o[ch];
            assign next_dac[ch] = clear ? clear_code
                : data_to_dac ? data
                : copy_to_dac ? input_reg_o[ch] : dac_code_o[ch];
        end
    endgenerate

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            dac_code_o <= '0;
            input_reg_o <= '0;
        end
        else
        begin
            dac_code_o <= next_dac;
            input_reg_o <= next_input;
        end
    end

    // ****************************************************************
    // Mask and reference setup
    // ****************************************************************
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || do_soft_reset)
        begin
            load_strobe_mask_o <= MASK_RESET;
            reference_off_o <= REF_RESET;
        end
        else
        begin
            if (do_mask)
            begin
                load_strobe_mask_o <= frame[MASK_MSB:MASK_LSB];
            end
            if (do_ref)
            begin
                reference_off_o <= frame[REF_BIT];
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_mask_load;
        @(posedge ref_clk_i) disable iff (rst_i)
        (frame_valid && initialised && frame[CMD_MSB:CMD_LSB] == CMD_STROBE_MASK)
            |=> load_strobe_mask_o == $past(frame[MASK_MSB:MASK_LSB]);
    endproperty
    a_mask_load: assert property (p_mask_load)
        else $error("mask not loaded from frame");

    property p_mask_reset;
        @(posedge ref_clk_i)
        $fell(rst_i) |-> (load_strobe_mask_o == MASK_RESET) && !reference_off_o;
    endproperty
    a_mask_reset: assert property (p_mask_reset)
        else $error("mask or reference not at reset value");

    property p_masked_hold;
        @(posedge ref_clk_i) disable iff (rst_i)
        (strobe_fall && load_strobe_mask_o[0] && !frame_valid && reset_n_i)
            |=> $stable(dac_code_o[0]);
    endproperty
    a_masked_hold: assert property (p_masked_hold)
        else $error("masked channel followed strobe edge");

    property p_strobe_copy;
        @(posedge ref_clk_i) disable iff (rst_i)
        ($fell(load_strobe_n_i) && initialised && reset_n_i
            && !load_strobe_mask_o[0] && !frame_valid)
            |=> dac_code_o[0] == $past(input_reg_o[0]);
    endproperty
    a_strobe_copy: assert property (p_strobe_copy)
        else $error("strobe edge did not copy input register");

    property p_write_in_high;
        @(posedge ref_clk_i) disable iff (rst_i)
        (do_write_in && addr[0] && load_strobe_n_i && reset_n_i && !strobe_fall)
            |=> $stable(dac_code_o[0]) && input_reg_o[0] == $past(data);
    endproperty
    a_write_in_high: assert property (p_write_in_high)
        else $error("write-input with strobe high changed DAC register");

    property p_write_in_low;
        @(posedge ref_clk_i) disable iff (rst_i)
        (do_write_in && addr[0] && !load_strobe_n_i && reset_n_i)
            |=> dac_code_o[0] == $past(data) && input_reg_o[0] == $past(data);
    endproperty
    a_write_in_low: assert property (p_write_in_low)
        else $error("write-input with strobe low missed DAC register");

    property p_update;
        @(posedge ref_clk_i) disable iff (rst_i)
        (do_update && addr[0] && reset_n_i)
            |=> $stable(input_reg_o[0]) && dac_code_o[0] == $past(input_reg_o[0]);
    endproperty
    a_update: assert property (p_update)
        else $error("update command wrong");

    property p_write_upd;
        @(posedge ref_clk_i) disable iff (rst_i)
        (do_write_upd && addr[0] && reset_n_i)
            |=> dac_code_o[0] == $past(data) && input_reg_o[0] == $past(data);
    endproperty
    a_write_upd: assert property (p_write_upd)
        else $error("write-and-update command wrong");

    property p_hw_clear;
        @(posedge ref_clk_i) disable iff (rst_i)
        !reset_n_i |=> dac_code_o[0] == ($past(reset_level_select_i) ? MID_CODE : ZERO_CODE)
            && dac_code_o[N_CH-1] == dac_code_o[0];
    endproperty
    a_hw_clear: assert property (p_hw_clear)
        else $error("reset pin did not clear outputs");

    property p_init_wait;
        @(posedge ref_clk_i) disable iff (rst_i)
        (state == ST_INIT && !reset_n_i) |=> state == ST_INIT ##0 !init_done_o;
    endproperty
    a_init_wait: assert property (p_init_wait)
        else $error("initialised while reset pin low");

    property p_soft_reset;
        @(posedge ref_clk_i) disable iff (rst_i)
        do_soft_reset |=> load_strobe_mask_o == MASK_RESET
            && input_reg_o[0] == ($past(reset_level_select_i) ? MID_CODE : ZERO_CODE);
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("software reset incomplete");

    property p_no_partial;
        @(posedge ref_clk_i) disable iff (rst_i)
        (!frame_valid && !strobe_fall && reset_n_i && initialised)
            |=> $stable(input_reg_o) && $stable(load_strobe_mask_o);
    endproperty
    a_no_partial: assert property (p_no_partial)
        else $error("registers changed without a whole frame");

    property p_ref_load;
        @(posedge ref_clk_i) disable iff (rst_i)
        do_ref |=> reference_off_o == $past(frame[REF_BIT]);
    endproperty
    a_ref_load: assert property (p_ref_load)
        else $error("reference bit not loaded from frame");

    property p_soft_ref;
        @(posedge ref_clk_i) disable iff (rst_i)
        do_soft_reset |=> !reference_off_o && dac_code_o[N_CH-1] == input_reg_o[N_CH-1];
    endproperty
    a_soft_ref: assert property (p_soft_ref)
        else $error("software reset left reference off");

    // Outputs track the select pin for as long as initialisation lasts
    property p_init_clear;
        @(posedge ref_clk_i) disable iff (rst_i)
        !initialised |=> dac_code_o[0] == ($past(reset_level_select_i) ? MID_CODE : ZERO_CODE)
            && input_reg_o[N_CH-1] == dac_code_o[0];
    endproperty
    a_init_clear: assert property (p_init_clear)
        else $error("outputs not at power-up code during initialisation");

    property p_masked_hold_ch2;
        @(posedge ref_clk_i) disable iff (rst_i)
        (strobe_fall && load_strobe_mask_o[2] && !frame_valid && reset_n_i)
            |=> $stable(dac_code_o[2]);
    endproperty
    a_masked_hold_ch2: assert property (p_masked_hold_ch2)
        else $error("masked channel two followed strobe edge");

    // Pin held low overrides the mask for direct writes
    property p_write_in_masked;
        @(posedge ref_clk_i) disable iff (rst_i)
        (do_write_in && addr[0] && !load_strobe_n_i && load_strobe_mask_o[0] && reset_n_i)
            |=> dac_code_o[0] == $past(data);
    endproperty
    a_write_in_masked: assert property (p_write_in_masked)
        else $error("masked write-input with strobe low missed DAC register");

    property p_reset_inputs;
        @(posedge ref_clk_i) disable iff (rst_i)
        !reset_n_i
            |=> input_reg_o[1] == ($past(reset_level_select_i) ? MID_CODE : ZERO_CODE);
    endproperty
    a_reset_inputs: assert property (p_reset_inputs)
        else $error("input register updated while reset pin low");

    // Release alone must not move any register
    property p_reset_hold;
        @(posedge ref_clk_i) disable iff (rst_i)
        ($rose(reset_n_i) && initialised && !frame_valid && !strobe_fall)
            |=> $stable(dac_code_o) && $stable(input_reg_o);
    endproperty
    a_reset_hold: assert property (p_reset_hold)
        else $error("outputs moved on reset pin release");

    property p_write_upd_ch1;
        @(posedge ref_clk_i) disable iff (rst_i)
        (do_write_upd && addr[1] && reset_n_i)
            |=> dac_code_o[1] == $past(data) && input_reg_o[1] == $past(data);
    endproperty
    a_write_upd_ch1: assert property (p_write_upd_ch1)
        else $error("write-and-update on channel one wrong");
endmodule

`default_nettype wire

/* dur_bus_master.sv */
`default_nettype none

// ****************************************************************
// Bus master model: hands over the acked bytes of one write frame
// ****************************************************************
module dur_bus_master
(
    input wire logic ref_clk_i,      // System clock
    output logic start_o,            // Start with address acked
    output logic byte_valid_o,       // Acked byte strobe
    output logic [7:0] byte_o,       // Acked byte
    output logic stop_o              // Stop pulse
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        start_o = 1'b0;
        byte_valid_o = 1'b0;
        byte_o = 8'hA5;
        stop_o = 1'b0;
    end

    // A short byte count cuts the frame; the gap lets the master run slowly
    task automatic send(input logic [23:0] frame, input int nbytes, input int gap);
        logic [7:0] b;
        @(negedge ref_clk_i);
        start_o = 1'b1;
        @(negedge ref_clk_i);
        start_o = 1'b0;
        for (int i = 0; i < nbytes; i++)
        begin
            b = frame[23 - 8 * i -: 8];
            byte_o = b;
            byte_valid_o = 1'b1;
            @(negedge ref_clk_i);
            byte_valid_o = 1'b0;
            // Released bus shows junk, so a stale byte cannot pass for data
            byte_o = ~b;
            repeat (gap) @(negedge ref_clk_i);
        end
        repeat (2) @(negedge ref_clk_i);
        stop_o = 1'b1;
        @(negedge ref_clk_i);
        stop_o = 1'b0;
    endtask
endmodule

`default_nettype wire

/* test_dac_update_reset_control.sv */
`default_nettype none

module test_dac_update_reset_control import dur_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic [23:0] frame;
        logic strobe_n;
        int ch;
        logic [15:0] exp_in;
        logic [15:0] exp_dac;
    } dur_row_s;

    logic ref_clk, rst, load_strobe_n, reset_n, reset_level_select;
    logic start, byte_valid, stop;
    logic [7:0] byte_b;
    logic [N_CH-1:0][DATA_W-1:0] dac_code, input_reg;
    logic [N_CH-1:0] mask;
    logic ref_off, init_done;
    int n_mismatch = 0;
    int comparisons = 0;
    dur_row_s rows [5];

    dur_bus_master i_dur_bus_master (.ref_clk_i(ref_clk), .start_o(start),
        .byte_valid_o(byte_valid), .byte_o(byte_b), .stop_o(stop));

    dur_ctrl i_dur_ctrl (.ref_clk_i(ref_clk), .rst_i(rst), .start_i(start),
        .byte_valid_i(byte_valid), .byte_i(byte_b), .stop_i(stop),
        .load_strobe_n_i(load_strobe_n), .reset_n_i(reset_n),
        .reset_level_select_i(reset_level_select), .dac_code_o(dac_code),
        .input_reg_o(input_reg), .load_strobe_mask_o(mask),
        .reference_off_o(ref_off), .init_done_o(init_done));

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // ****************************************************************
    // Compare and control tasks
    // ****************************************************************
    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk4(input string what, input logic [3:0] exp, input logic [3:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wait_init;
        int k;
        k = 0;
        while (init_done !== 1'b1 && k < 20)
        begin
            cyc(1);
            k++;
        end
        chk4("init_done", 4'h1, {3'h0, init_done});
        if (k == 20)
            end_sim();
    endtask

    task automatic send(input logic [23:0] frame);
        i_dur_bus_master.send(frame, 3, 0);
        cyc(1);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        rst = 1'b1;
        load_strobe_n = 1'b1;
        reset_n = 1'b1;
        reset_level_select = 1'b0;
        rows = '{'{24'h111234, 1'b1, 0, 16'h1234, 16'h0000},
                 '{24'h21FFFF, 1'b1, 0, 16'h1234, 16'h1234},
                 '{24'h32ABCD, 1'b1, 1, 16'hABCD, 16'hABCD},
                 '{24'h145555, 1'b0, 2, 16'h5555, 16'h5555},
                 '{24'h180F0F, 1'b1, 3, 16'h0F0F, 16'h0000}};
        cyc(3);
        rst = 1'b0;
        wait_init();
        chk4("mask", MASK_RESET, mask);
        chk4("reference_off", 4'h0, {3'h0, ref_off});
        chk16("dac0", ZERO_CODE, dac_code[0]);
        $display("reset test done");
        foreach (rows[i])
        begin
            load_strobe_n = rows[i].strobe_n;
            cyc(1);
            // Odd rows go slowly, with idle cycles between bytes
            i_dur_bus_master.send(rows[i].frame, 3, i % 2);
            cyc(1);
            chk16("input_reg", rows[i].exp_in, input_reg[rows[i].ch]);
            chk16("dac_code", rows[i].exp_dac, dac_code[rows[i].ch]);
        end
        $display("command table test done");
        load_strobe_n = 1'b1;
        send(24'h5F0005);
        chk4("mask", 4'h5, mask);
        send(24'h111111);
        chk16("input0", 16'h1111, input_reg[0]);
        chk16("dac0", 16'h1234, dac_code[0]);
        load_strobe_n = 1'b0;
        cyc(2);
        chk16("dac0", 16'h1234, dac_code[0]);
        chk16("dac3", 16'h0F0F, dac_code[3]);
        send(24'h112222);
        chk16("dac0", 16'h2222, dac_code[0]);
        load_strobe_n = 1'b1;
        send(24'h7F0001);
        chk4("reference_off", 4'h1, {3'h0, ref_off});
        send(24'h700000);
        chk4("reference_off", 4'h0, {3'h0, ref_off});
        i_dur_bus_master.send(24'h139999, 2, 0);
        cyc(1);
        chk16("input0", 16'h2222, input_reg[0]);
        send(24'h314321);
        chk16("input0", 16'h4321, input_reg[0]);
        chk16("dac0", 16'h4321, dac_code[0]);
        $display("mask and reference test done");
        send(24'h7F0001);
        send(24'h600000);
        chk16("dac1", ZERO_CODE, dac_code[1]);
        chk16("input2", ZERO_CODE, input_reg[2]);
        chk4("mask", MASK_RESET, mask);
        chk4("reference_off", 4'h0, {3'h0, ref_off});
        reset_level_select = 1'b1;
        reset_n = 1'b0;
        cyc(2);
        chk16("dac1", MID_CODE, dac_code[1]);
        send(24'h32ABCD);
        chk16("dac1", MID_CODE, dac_code[1]);
        reset_n = 1'b1;
        cyc(3);
        chk16("dac1", MID_CODE, dac_code[1]);
        chk16("input1", MID_CODE, input_reg[1]);
        $display("reset pin test done");
        rst = 1'b1;
        reset_n = 1'b0;
        cyc(3);
        rst = 1'b0;
        load_strobe_n = 1'b0;
        cyc(2);
        load_strobe_n = 1'b1;
        cyc(3);
        chk4("init_done", 4'h0, {3'h0, init_done});
        reset_n = 1'b1;
        wait_init();
        chk16("dac2", MID_CODE, dac_code[2]);
        $display("power-up test done");
        end_sim();
    end
endmodule

`default_nettype wire
